// [logic/serial_port_params.svh]
// Register map, field codes and timing constants of the serial command port
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH
// ****************************************
// Register word indices
// ****************************************
`define REG_CTRL 3'h0
`define REG_STAT 3'h1
`define REG_MASK 3'h2
`define REG_RXD 3'h3
`define REG_TXD 3'h4
`define REG_STATE 3'h5
`define REG_RCMD 3'h6
// ****************************************
// Field codes and reset values
// ****************************************
`define CFG_W 12
`define CFG_RESET 12'h481
`define EVT_W 6
`define PAR_NONE 2'h0
`define PAR_ODD 2'h1
`define FLOW_NONE 2'h0
`define FLOW_SW 2'h1
`define FLOW_RTS 2'h2
`define EOL_CR 2'h0
`define EOL_LF 2'h1
`define CMD_REMOTE 2'h1
`define CMD_LOCAL 2'h2
`define CMD_LOCKOUT 2'h3
`define TXD_EOL_BIT 8
`define RXD_VALID_BIT 8
// ****************************************
// Control characters
// ****************************************
`define CH_ETX 8'h03
`define CH_LF 8'h0a
`define CH_CR 8'h0d
`define CH_XON 8'h11
`define CH_XOFF 8'h13
// ****************************************
// Bit rates in baud and default clock in Hz
// ****************************************
`define BAUD_0 9600
`define BAUD_1 19200
`define BAUD_2 38400
`define BAUD_3 57600
`define BAUD_4 115200
`define CLK_HZ_DEFAULT 50000000
`endif

// [logic/serial_port_pkg.sv]
// Types shared by the serial command port
package serial_port_pkg;
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_START = 5'b00010,
		S_DATA = 5'b00100,
		S_PAR = 5'b01000,
		S_STOP = 5'b10000
	} frame_e;
	typedef enum logic [3:0] {
		RL_LOCAL = 4'b0001,
		RL_REMOTE = 4'b0010,
		RL_LLOCK = 4'b0100,
		RL_RLOCK = 4'b1000
	} rl_e;
	typedef struct packed {
		logic pud;
		logic [1:0] line_terminator;
		logic [1:0] flow;
		logic [2:0] baud;
		logic [1:0] parity;
		logic stop2;
		logic data8;
	} cfg_s;
	typedef struct packed {
		logic tx_done;
		logic frame_err;
		logic parity_err;
		logic dev_clear;
		logic line_end;
		logic rx_char;
	} evt_s;
endpackage

// [logic/serial_remote_command_port.sv]
// Serial remote command port: framer, receive front end and register slave
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_params.svh"
module serial_remote_command_port #(
	parameter int CLK_HZ = `CLK_HZ_DEFAULT,
	parameter logic [1:0] PORT_ID = 2'h0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [2:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic rxd,
	output logic txd,
	input wire logic cts_n,
	output logic rts_n,
	output logic irq,
	output logic dev_clear,
	output serial_port_pkg::rl_e rl_state,
	output logic panel_lock
);
	import serial_port_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	// Bit period in clocks for the selected rate
	function automatic logic [15:0] bit_div(input logic [2:0] sel);
		int r;
		case (sel)
			3'h1: r = `BAUD_1;
			3'h2: r = `BAUD_2;
			3'h3: r = `BAUD_3;
			3'h4: r = `BAUD_4;
			default: r = `BAUD_0;
		endcase
		return 16'(CLK_HZ / r);
	endfunction

	// Parity bit over the active data bits
	function automatic logic par_bit(input logic [7:0] d, input cfg_s c);
		logic x;
		x = ^(c.data8 ? d : {1'b0, d[6:0]});
		return (c.parity == `PAR_ODD) ? ~x : x;
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	cfg_s cfg_q, cfg_d;
	evt_s stat_q, stat_d, mask_q, mask_d, evt;
	rl_e rl_q, rl_d;
	logic [1:0] owner_q, owner_d;
	logic ack_q, ack_d, stall, acc, wr_tx;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] hold_q, hold_d;
	logic hvalid_q, hvalid_d, xoff_q, xoff_d, dclr_q, dclr_d;
	logic [2:0] rx_s_q, cts_s_q;
	logic rx_line_q, cts_line_q;
	frame_e rx_st_q, rx_st_d, tx_st_q, tx_st_d;
	logic [15:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d, div;
	logic [2:0] rx_idx_q, rx_idx_d, tx_idx_q, tx_idx_d;
	logic [7:0] rx_sh_q, rx_sh_d, tx_sh_q, tx_sh_d;
	logic rx_perr_q, rx_perr_d, rx_done, rx_ok, rx_ferr;
	logic [2:0] last_idx;
	logic tx_q, tx_d, tpend_q, tpend_d, tx_go, tx_end;
	logic [7:0] tbyte_q, tbyte_d;
	logic [1:0] teol_q, teol_d;

	// Counters run down to zero inclusive, so reload with one less than the bit time
	assign div = bit_div(cfg_q.baud) - 16'h1;
	assign last_idx = cfg_q.data8 ? 3'h7 : 3'h6;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Three stages; a level counts only once the last two agree
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_s_q <= 3'h7;
			cts_s_q <= 3'h7;
			rx_line_q <= 1'b1;
			cts_line_q <= 1'b1;
		end else if (ce) begin
			rx_s_q <= {rx_s_q[1:0], rxd};
			cts_s_q <= {cts_s_q[1:0], cts_n};
			if (rx_s_q[1] == rx_s_q[2]) rx_line_q <= rx_s_q[2];
			if (cts_s_q[1] == cts_s_q[2]) cts_line_q <= cts_s_q[2];
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	// Samples mid-bit; a false start drops back to idle
	always_comb begin
		rx_st_d = rx_st_q;
		rx_cnt_d = rx_cnt_q;
		rx_idx_d = rx_idx_q;
		rx_sh_d = rx_sh_q;
		rx_perr_d = rx_perr_q;
		rx_done = 1'b0;
		rx_ferr = 1'b0;
		if (rx_st_q != S_IDLE && rx_cnt_q != 16'h0) rx_cnt_d = rx_cnt_q - 16'h1;
		case (rx_st_q)
			S_IDLE: begin
				if (!rx_line_q) begin
					rx_st_d = S_START;
					rx_cnt_d = {1'b0, div[15:1]};
					rx_perr_d = 1'b0;
					rx_sh_d = 8'h0;
				end
			end
			S_START: if (rx_cnt_q == 16'h0) begin
				rx_st_d = rx_line_q ? S_IDLE : S_DATA;
				rx_cnt_d = div;
				rx_idx_d = 3'h0;
			end
			S_DATA: if (rx_cnt_q == 16'h0) begin
				rx_sh_d[rx_idx_q] = rx_line_q;
				rx_cnt_d = div;
				rx_idx_d = rx_idx_q + 3'h1;
				if (rx_idx_q == last_idx) rx_st_d = (cfg_q.parity == `PAR_NONE) ? S_STOP : S_PAR;
			end
			S_PAR: if (rx_cnt_q == 16'h0) begin
				rx_perr_d = rx_line_q != par_bit(rx_sh_q, cfg_q);
				rx_st_d = S_STOP;
				rx_cnt_d = div;
			end
			S_STOP: if (rx_cnt_q == 16'h0) begin
				rx_st_d = S_IDLE;
				rx_done = 1'b1;
				rx_ferr = !rx_line_q;
			end
			default: rx_st_d = S_IDLE;
		endcase
	end
	assign rx_ok = rx_done && !rx_ferr && !rx_perr_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_st_q <= S_IDLE;
			rx_cnt_q <= 16'h0;
			rx_idx_q <= 3'h0;
			rx_sh_q <= 8'h0;
			rx_perr_q <= 1'b0;
		end else if (ce) begin
			rx_st_q <= rx_st_d;
			rx_cnt_q <= rx_cnt_d;
			rx_idx_q <= rx_idx_d;
			rx_sh_q <= rx_sh_d;
			rx_perr_q <= rx_perr_d;
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	// Suspension is checked only between characters
	assign tx_go = !(cfg_q.flow == `FLOW_SW && xoff_q) && !(cfg_q.flow == `FLOW_RTS && cts_line_q);
	always_comb begin
		tx_st_d = tx_st_q;
		tx_cnt_d = tx_cnt_q;
		tx_idx_d = tx_idx_q;
		tx_sh_d = tx_sh_q;
		tx_d = tx_q;
		tpend_d = tpend_q;
		tbyte_d = tbyte_q;
		teol_d = teol_q;
		tx_end = 1'b0;
		if (wr_tx) begin
			if (writedata[`TXD_EOL_BIT]) begin
				teol_d = {cfg_q.line_terminator != `EOL_CR, cfg_q.line_terminator != `EOL_LF};
			end else begin
				tpend_d = 1'b1;
				tbyte_d = writedata[7:0];
			end
		end
		if (tx_st_q != S_IDLE && tx_cnt_q != 16'h0) tx_cnt_d = tx_cnt_q - 16'h1;
		case (tx_st_q)
			S_IDLE: if ((tpend_q || teol_q != 2'h0) && tx_go) begin
				tx_st_d = S_START;
				tx_cnt_d = div;
				tx_d = 1'b0;
				if (teol_q[0]) begin
					tx_sh_d = `CH_CR;
					teol_d[0] = 1'b0;
				end else if (teol_q[1]) begin
					tx_sh_d = `CH_LF;
					teol_d[1] = 1'b0;
				end else begin
					tx_sh_d = tbyte_q;
					tpend_d = 1'b0;
				end
			end
			S_START: if (tx_cnt_q == 16'h0) begin
				tx_st_d = S_DATA;
				tx_cnt_d = div;
				tx_idx_d = 3'h0;
				tx_d = tx_sh_q[0];
			end
			S_DATA: if (tx_cnt_q == 16'h0) begin
				tx_cnt_d = div;
				tx_idx_d = tx_idx_q + 3'h1;
				tx_d = tx_sh_q[tx_idx_d];
				if (tx_idx_q == last_idx) begin
					tx_st_d = (cfg_q.parity == `PAR_NONE) ? S_STOP : S_PAR;
					tx_d = (cfg_q.parity == `PAR_NONE) ? 1'b1 : par_bit(tx_sh_q, cfg_q);
					tx_idx_d = 3'h0;
				end
			end
			S_PAR: if (tx_cnt_q == 16'h0) begin
				tx_st_d = S_STOP;
				tx_cnt_d = div;
				tx_d = 1'b1;
			end
			S_STOP: if (tx_cnt_q == 16'h0) begin
				tx_cnt_d = div;
				tx_idx_d = 3'h1;
				if (tx_idx_q == 3'h1 || !cfg_q.stop2) begin
					tx_st_d = S_IDLE;
					tx_end = 1'b1;
				end
			end
			default: tx_st_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			tx_st_q <= S_IDLE;
			tx_cnt_q <= 16'h0;
			tx_idx_q <= 3'h0;
			tx_sh_q <= 8'h0;
			tx_q <= 1'b1;
			tpend_q <= 1'b0;
			tbyte_q <= 8'h0;
			teol_q <= 2'h0;
		end else if (ce) begin
			tx_st_q <= tx_st_d;
			tx_cnt_q <= tx_cnt_d;
			tx_idx_q <= tx_idx_d;
			tx_sh_q <= tx_sh_d;
			tx_q <= tx_d;
			tpend_q <= tpend_d;
			tbyte_q <= tbyte_d;
			teol_q <= teol_d;
		end
	end
	assign txd = tx_q;
	// Hold full means the host must pause
	assign rts_n = (cfg_q.flow == `FLOW_RTS) ? hvalid_q : 1'b0;

	// ****************************************
	// Bus slave, front end and remote state
	// ****************************************
	// One wait cycle per access; a text write waits while an earlier character or terminator is still pending
	assign stall = write && address == `REG_TXD && (tpend_q || teol_q != 2'h0);
	assign waitrequest = (read || write) && !ack_q;
	assign acc = (read || write) && ack_q;
	assign wr_tx = acc && write && address == `REG_TXD;
	always_comb begin
		cfg_d = cfg_q;
		mask_d = mask_q;
		rl_d = rl_q;
		owner_d = owner_q;
		hold_d = hold_q;
		hvalid_d = hvalid_q;
		xoff_d = xoff_q;
		dclr_d = 1'b0;
		evt = '0;
		ack_d = (read || write) && !ack_q && !stall;
		rdata_d = rdata_q;
		// Character sorting on good frames
		evt.parity_err = rx_done && rx_perr_q;
		evt.frame_err = rx_ferr;
		evt.tx_done = tx_end;
		if (rx_ok) begin
			case (rx_sh_q)
				`CH_ETX: begin
					dclr_d = 1'b1;
					evt.dev_clear = 1'b1;
				end
				`CH_XOFF, `CH_XON: begin
					if (cfg_q.flow == `FLOW_SW) xoff_d = rx_sh_q == `CH_XOFF;
				end
				`CH_CR, `CH_LF: begin
					evt.line_end = 1'b1;
					cfg_d.pud = 1'b0;
					if (!cfg_q.pud) begin
						hold_d = rx_sh_q;
						hvalid_d = 1'b1;
					end
				end
				default: begin
					hold_d = rx_sh_q;
					hvalid_d = 1'b1;
					evt.rx_char = 1'b1;
				end
			endcase
		end
		// Sticky status: a new event beats a clear in the same cycle
		stat_d = stat_q | evt;
		if (ack_d && read) begin
			case (address)
				`REG_CTRL: rdata_d = 32'(cfg_q);
				`REG_STAT: rdata_d = 32'(stat_q);
				`REG_MASK: rdata_d = 32'(mask_q);
				`REG_RXD: rdata_d = 32'({hvalid_q, hold_q});
				`REG_STATE: rdata_d = 32'({owner_q, rl_q, xoff_q, tx_st_q != S_IDLE});
				default: rdata_d = 32'h0;
			endcase
		end
		if (acc && read && address == `REG_RXD) hvalid_d = evt.rx_char || (rx_ok && hvalid_d && hvalid_q == 1'b0);
		if (acc && write) begin
			case (address)
				`REG_CTRL: cfg_d = cfg_s'(writedata[`CFG_W-1:0]);
				`REG_STAT: stat_d = (stat_q & ~evt_s'(writedata[`EVT_W-1:0])) | evt;
				`REG_MASK: mask_d = evt_s'(writedata[`EVT_W-1:0]);
				`REG_RCMD: begin
					case (writedata[1:0])
						`CMD_REMOTE: rl_d = (rl_q == RL_LLOCK) ? RL_RLOCK : ((rl_q == RL_LOCAL) ? RL_REMOTE : rl_q);
						`CMD_LOCKOUT: begin
							if (rl_q == RL_LOCAL || rl_q == RL_REMOTE) owner_d = writedata[3:2];
							rl_d = (rl_q == RL_REMOTE || rl_q == RL_RLOCK) ? RL_RLOCK : RL_LLOCK;
						end
						`CMD_LOCAL: begin
							if (rl_q == RL_REMOTE) rl_d = RL_LOCAL;
							else if (rl_q == RL_RLOCK && writedata[3:2] == owner_q) rl_d = RL_LLOCK;
						end
						default: rl_d = rl_q;
					endcase
				end
				default: cfg_d = cfg_q;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_q <= cfg_s'(`CFG_RESET);
			stat_q <= '0;
			mask_q <= '0;
			rl_q <= RL_LOCAL;
			owner_q <= 2'h0;
			hold_q <= 8'h0;
			hvalid_q <= 1'b0;
			xoff_q <= 1'b0;
			dclr_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else if (ce) begin
			cfg_q <= cfg_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			rl_q <= rl_d;
			owner_q <= owner_d;
			hold_q <= hold_d;
			hvalid_q <= hvalid_d;
			xoff_q <= xoff_d;
			dclr_q <= dclr_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end
	assign readdata = rdata_q;
	assign irq = |(stat_q & mask_q);
	assign dev_clear = dclr_q;
	assign rl_state = rl_q;
	assign panel_lock = rl_q == RL_RLOCK;

	// ****************************************
	// Assertions
	// ****************************************
	AST_CFG_DEFAULT: assert property (@(posedge clk) $past(!nrst) && nrst |-> cfg_q == cfg_s'(`CFG_RESET))
		else $error("config not at default after reset");
	AST_ETX_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
		ce && rx_ok && rx_sh_q == `CH_ETX |=> dev_clear && $stable(hold_q) && stat_q.dev_clear)
		else $error("ctrl-c did not raise a clear or was stored");
	AST_LINE_END: assert property (@(posedge clk) disable iff (!nrst)
		ce && rx_ok && (rx_sh_q == `CH_CR || rx_sh_q == `CH_LF) |=> stat_q.line_end && !cfg_q.pud)
		else $error("line end not flagged");
	AST_PUD_FILTER: assert property (@(posedge clk) disable iff (!nrst)
		ce && rx_ok && cfg_q.pud && rx_sh_q == `CH_LF |=> hold_q == $past(hold_q))
		else $error("terminator stored in protected data");
	AST_XOFF_SUSPEND: assert property (@(posedge clk) disable iff (!nrst)
		ce && rx_ok && rx_sh_q == `CH_XOFF && cfg_q.flow == `FLOW_SW |=> xoff_q)
		else $error("xoff did not suspend");
	AST_NO_START: assert property (@(posedge clk) disable iff (!nrst)
		tx_st_q == S_IDLE && xoff_q && cfg_q.flow == `FLOW_SW |=> tx_st_q == S_IDLE && txd)
		else $error("character started while suspended");
	AST_FRAME_ERR: assert property (@(posedge clk) disable iff (!nrst)
		ce && rx_ferr |=> stat_q.frame_err && rx_st_q == S_IDLE)
		else $error("frame error not flagged");
	AST_REMOTE: assert property (@(posedge clk) disable iff (!nrst)
		ce && acc && write && address == `REG_RCMD && writedata[1:0] == `CMD_REMOTE && rl_q == RL_LOCAL
		|=> rl_q == RL_REMOTE)
		else $error("remote command ignored");
	AST_BUS_WAIT: assert property (@(posedge clk) disable iff (!nrst)
		$rose(read) && ce |-> waitrequest ##1 !waitrequest)
		else $error("read not answered after one wait cycle");
endmodule // serial_remote_command_port
`default_nettype wire

// [verif/serial_host_model.sv]
// Host terminal model on the far end of the null-modem link
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
	input wire logic clk,
	input wire logic txd,
	output logic rxd,
	output logic cts_n
);
	// ****************************************
	// Frame settings, set by the bench to match the port
	// ****************************************
	int bit_clks = 120;
	logic data8 = 1'b1;
	logic stop2 = 1'b0;
	logic [1:0] par = 2'h0;
	logic [7:0] rx_q[$];
	initial begin
		rxd = 1'b1;
		cts_n = 1'b0;
	end
	// Sends one frame, LSB first; faults only when the bench asks
	task automatic send(input logic [7:0] ch, input logic bad_par, input logic bad_stop);
		logic p;
		p = (data8 ? ^ch : ^ch[6:0]) ^ (par == 2'h1) ^ bad_par;
		@(posedge clk);
		rxd <= 1'b0;
		repeat (bit_clks) @(posedge clk);
		for (int i = 0; i < (data8 ? 8 : 7); i++) begin
			rxd <= ch[i];
			repeat (bit_clks) @(posedge clk);
		end
		if (par != 2'h0) begin
			rxd <= p;
			repeat (bit_clks) @(posedge clk);
		end
		rxd <= ~bad_stop;
		repeat (bit_clks * (stop2 ? 2 : 1)) @(posedge clk);
		// Idle gap so a missing stop bit cannot merge into the next start
		rxd <= 1'b1;
		repeat (bit_clks) @(posedge clk);
	endtask
	// Receiver samples mid bit and queues each character
	always begin : host_rx
		logic [7:0] ch;
		@(negedge txd);
		ch = 8'h00;
		repeat (bit_clks / 2) @(posedge clk);
		for (int i = 0; i < (data8 ? 8 : 7); i++) begin
			repeat (bit_clks) @(posedge clk);
			ch[i] = txd;
		end
		repeat (bit_clks * ((par != 2'h0) ? 2 : 1)) @(posedge clk);
		rx_q.push_back(ch);
	end
endmodule // serial_host_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the serial remote command port
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_params.svh"
module tb;
	import serial_port_pkg::*;
	logic clk = 1'b0;
	logic nrst, ce, read, write, rxd, cts_n;
	logic [2:0] address;
	logic [31:0] writedata, readdata, q;
	logic waitrequest, txd, rts_n, irq, dev_clear, panel_lock;
	rl_e rl_state;
	logic [7:0] c;
	int fails = 0;
	int comparisons = 0;
	int clr_cnt = 0;
	logic [11:0] cfgs[4] = '{12'h4ca, 12'h4c5, 12'h4c3, 12'h4c0};
	logic [3:0] cmds[5] = '{4'h5, 4'h7, 4'ha, 4'h6, 4'h5};
	logic [3:0] exps[5] = '{4'b0010, 4'b1000, 4'b1000, 4'b0100, 4'b1000};
	// 50 MHz clock
	always #10 clk = ~clk;
	// Counts one-cycle clear pulses
	always @(posedge clk) if (dev_clear === 1'b1) clr_cnt <= clr_cnt + 1;
	// 10 clocks per bit at the top rate keeps the run short
	serial_remote_command_port #(.CLK_HZ(1152000), .PORT_ID(2'h0)) u_dut (.clk(clk), .nrst(nrst), .ce(ce),
		.address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .irq(irq),
		.dev_clear(dev_clear), .rl_state(rl_state), .panel_lock(panel_lock));
	serial_host_model u_host (.clk(clk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
	// ****************************************
	// Bus, compare and report tasks
	// ****************************************
	task automatic results();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr_en, input logic [2:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk);
		read <= ~wr_en;
		write <= wr_en;
		address <= a;
		writedata <= d;
		for (n = 0; n < 20000; n++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) break;
		end
		if (n == 20000) begin
			fails++;
			results();
		end
		// Taken at the edge where waitrequest is seen low, released right after it
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [2:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask
	// Bounded wait for a character seen by the host
	task automatic get(output logic [7:0] ch);
		for (int n = 0; n < 5000 && u_host.rx_q.size() == 0; n++) @(posedge clk);
		if (u_host.rx_q.size() == 0) begin
			fails++;
			results();
		end
		ch = u_host.rx_q.pop_front();
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 3'h0;
		writedata = 32'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(`REG_CTRL, q);
		chk(q, 32'h481);
		chk({28'h0, rl_state}, 32'h1);
		u_host.send(8'h41, 1'b0, 1'b0);
		rd(`REG_RXD, q);
		chk(q, 32'h141);
		wr(`REG_MASK, 32'h1);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(`REG_STAT, 32'h3f);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		u_host.bit_clks = 10;
		// Frame formats in both directions
		for (int i = 0; i < 4; i++) begin
			wr(`REG_CTRL, {20'h0, cfgs[i]});
			u_host.data8 = cfgs[i][0];
			u_host.stop2 = cfgs[i][1];
			u_host.par = cfgs[i][3:2];
			u_host.send(8'hd5, 1'b0, 1'b0);
			rd(`REG_RXD, q);
			chk(q, cfgs[i][0] ? 32'h1d5 : 32'h155);
			wr(`REG_TXD, 32'ha6);
			get(c);
			chk(c, cfgs[i][0] ? 8'ha6 : 8'h26);
		end
		u_host.data8 = 1'b1;
		u_host.stop2 = 1'b0;
		u_host.par = 2'h0;
		// Every output terminator choice
		for (int e = 0; e < 3; e++) begin
			wr(`REG_CTRL, 32'h0c1 | (e << 9));
			wr(`REG_TXD, 32'h100);
			get(c);
			chk(c, e == 1 ? 8'h0a : 8'h0d);
			if (e == 2) get(c);
			if (e == 2) chk(c, 8'h0a);
		end
		// Protected data: controls act but are not stored, LF ends the mode
		wr(`REG_CTRL, 32'hcc1);
		// Let the last terminator's stop bit finish before clearing status
		repeat (20) @(posedge clk);
		wr(`REG_STAT, 32'h3f);
		u_host.send(8'h78, 1'b0, 1'b0);
		u_host.send(8'h03, 1'b0, 1'b0);
		u_host.send(8'h13, 1'b0, 1'b0);
		u_host.send(8'h11, 1'b0, 1'b0);
		u_host.send(8'h0a, 1'b0, 1'b0);
		rd(`REG_RXD, q);
		chk(q, 32'h178);
		rd(`REG_CTRL, q);
		chk(q, 32'h4c1);
		rd(`REG_STAT, q);
		chk(q, 32'h07);
		chk(clr_cnt, 1);
		// Outside protected mode CR is stored and ends the line
		wr(`REG_STAT, 32'h3f);
		u_host.send(8'h0d, 1'b0, 1'b0);
		rd(`REG_RXD, q);
		chk(q, 32'h10d);
		rd(`REG_STAT, q);
		chk(q, 32'h02);
		u_host.send(8'h03, 1'b0, 1'b0);
		chk(clr_cnt, 2);
		// Suspend and resume transmission
		u_host.send(8'h13, 1'b0, 1'b0);
		rd(`REG_STATE, q);
		chk(q[1], 1'b1);
		wr(`REG_TXD, 32'h7a);
		repeat (300) @(posedge clk);
		chk(u_host.rx_q.size(), 0);
		u_host.send(8'h11, 1'b0, 1'b0);
		get(c);
		chk(c, 8'h7a);
		rd(`REG_RXD, q);
		chk(q[8], 1'b0);
		// Parity and stop faults, then a good character
		wr(`REG_CTRL, 32'h4c9);
		u_host.par = 2'h2;
		wr(`REG_STAT, 32'h3f);
		u_host.send(8'h55, 1'b1, 1'b0);
		u_host.send(8'h55, 1'b0, 1'b1);
		u_host.send(8'h66, 1'b0, 1'b0);
		rd(`REG_RXD, q);
		chk(q, 32'h166);
		rd(`REG_STAT, q);
		chk(q, 32'h19);
		wr(`REG_MASK, 32'h18);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(`REG_STAT, 32'h18);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		// Hardware handshake on both lines
		wr(`REG_CTRL, 32'h541);
		u_host.par = 2'h0;
		u_host.send(8'h31, 1'b0, 1'b0);
		chk({31'h0, rts_n}, 32'h1);
		rd(`REG_RXD, q);
		@(negedge clk);
		chk({31'h0, rts_n}, 32'h0);
		u_host.cts_n <= 1'b1;
		// Give the three-stage synchroniser time to see the pause
		repeat (4) @(posedge clk);
		wr(`REG_TXD, 32'h32);
		repeat (300) @(posedge clk);
		chk(u_host.rx_q.size(), 0);
		u_host.cts_n <= 1'b0;
		get(c);
		chk(c, 8'h32);
		// Remote, local and lockout commands with issuer check
		for (int i = 0; i < 5; i++) begin
			wr(`REG_RCMD, {28'h0, cmds[i]});
			rd(`REG_STATE, q);
			chk(q[5:2], exps[i]);
			chk({28'h0, rl_state}, {28'h0, exps[i]});
		end
		chk({31'h0, panel_lock}, 32'h1);
		rd(3'h7, q);
		chk(q, 32'h0);
		results();
	end
endmodule // tb
`default_nettype wire
